// ### shared/wdrc_pkg.sv
// Purpose: constants for the watchdog and reset-control block
// Assumes: classic wishbone slave with 32-bit data, word aligned registers
// Notes: one name for each offset, field, reset value and count
package wdrc_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] WDRC_OFF_WDT_CTRL = 8'h00;
    localparam logic [7:0] WDRC_OFF_RST_FLAGS = 8'h04;
    localparam logic [7:0] WDRC_OFF_PROG_CTRL = 8'h08;
    localparam logic [7:0] WDRC_OFF_STATUS = 8'h0C;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int WDRC_KEY_LSB = 3;
    localparam int WDRC_SEL_LSB = 0;
    localparam logic [4:0] WDRC_KEY_A = 5'h0A;
    localparam logic [4:0] WDRC_KEY_B = 5'h15;
    localparam logic [2:0] WDRC_SEL_RESET = 3'h3;
    localparam logic [7:0] WDRC_WDT_CTRL_RESET = 8'h53;
    localparam int WDRC_LVR_FLAG_BIT = 2;
    localparam int WDRC_KEY_ERR_FLAG_BIT = 0;
    localparam int WDRC_ST_TIMEOUT_BIT = 0;
    localparam int WDRC_ST_PDOWN_BIT = 1;
    localparam int WDRC_ST_ENABLED_BIT = 2;
    localparam logic [7:0] WDRC_PROG_RESET_CODE = 8'h55;

    // ****************************************
    // timing
    // ****************************************
    // widest select tests bit 18, so the counter needs bits 18 down to 0
    localparam int WDRC_CNT_W = 19;
    localparam int WDRC_KEY_ERR_DELAY_LS = 4;
    localparam int WDRC_LV_FILTER_LS = 4;
    localparam int WDRC_RESET_PULSE_CYC = 2;

    typedef enum logic [1:0] {
        WDRC_RUN,
        WDRC_KEY_WAIT,
        WDRC_RESETTING
    } wdrc_state_t;

endpackage : wdrc_pkg

// ### verilog/wdrc_lv_filter.sv
// Purpose: qualify the low-supply indication over low-speed clock ticks
// Assumes: low_i and tick_i synchronous to clk_i
// Notes: the count restarts whenever the indication drops or is disabled
module wdrc_lv_filter #(
    parameter int FILTER_TICKS = wdrc_pkg::WDRC_LV_FILTER_LS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // inputs
    input wire logic tick_i,
    input wire logic enable_i,
    input wire logic low_i,
    // result
    output logic fire_o
);

    logic [15:0] cnt_reg;

    // ****************************************
    // filter
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_i || !low_i) begin
            cnt_reg <= 16'h0000;
        end else if (tick_i && cnt_reg <= 16'(FILTER_TICKS)) begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    // must last strictly longer than the filter time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fire_o <= 1'b0;
        end else begin
            fire_o <= enable_i && low_i && (cnt_reg > 16'(FILTER_TICKS));
        end
    end

endmodule : wdrc_lv_filter

// ### verilog/wdrc_top.sv
// Purpose: watchdog timer and reset-source control with a wishbone slave
// Assumes: low_speed_internal_osc_tick_i is one clk_i pulse per low-speed oscillator period
// Notes: rst_i stands for power-on reset; reset requests leave as pulses
//
// Function
// - watchdog overflow outside power-down resets the device unless software cleared it first
// - watchdog runs only while the key field holds 01010 or 10101
// - any other key value resets the device after a fixed delay
// - key field starts at 01010 so the watchdog runs from power-on
// - timeout while running: device reset and timeout flag set
// - timeout in power-down: set timeout and power-down, reset pc and sp only
// - counter cleared by bad key write, clear instruction or halt
// - timeout ranges from 2^8 to 2^18 low-speed clocks
// - after power-on the program counter starts at zero
// - after power-on all port data and direction registers read high
// - low-voltage reset always active in fast and slow modes
// - qualified low supply resets device and sets low-voltage flag
// - low supply not longer than filter time is ignored
// - low-voltage reset disabled in sleep or idle
// - low-voltage flag set by hardware, cleared only by software zero write
// - reset-flag bits 7 to 3 and bit 1 read as zero
// - writing 55h to the programming control register resets the device
// - select codes give 2^8,10,12,14 then 2^15 through 2^18
// - key-error flag set by key reset, cleared only by software zero write
// - power-down flag set by halt, cleared at power-up or clear instruction
module wdrc_top #(
    parameter int KEY_ERR_DELAY = wdrc_pkg::WDRC_KEY_ERR_DELAY_LS,
    parameter int LV_FILTER = wdrc_pkg::WDRC_LV_FILTER_LS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // core and system
    input wire logic low_speed_internal_osc_tick_i,
    input wire logic clear_wdt_i,
    input wire logic halt_i,
    input wire logic low_supply_i,
    // reset outputs
    output logic device_reset_o,
    output logic pc_sp_reset_o,
    output logic timeout_flag_o,
    output logic power_down_flag_o
);

    // ****************************************
    // declarations
    // ****************************************
    logic [7:0] wdt_ctrl_reg;
    logic lv_flag_reg;
    logic key_flag_reg;
    logic [wdrc_pkg::WDRC_CNT_W-1:0] wdt_cnt_reg;
    logic [15:0] key_cnt_reg;
    logic [1:0] pulse_cnt_reg;
    wdrc_pkg::wdrc_state_t state_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic bus_req;
    logic wr_fire;
    logic hit;
    logic ctrl_wr;
    logic key_valid;
    logic key_write_bad;
    logic overflow;
    logic lv_fire;
    logic wdt_clear;
    logic prog_reset;
    logic full_reset_req;
    logic [4:0] key_field;
    logic [2:0] sel_field;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic key_ok(input logic [4:0] k);
        return (k == wdrc_pkg::WDRC_KEY_A) || (k == wdrc_pkg::WDRC_KEY_B);
    endfunction : key_ok

    // overflow bit position for the select code
    function automatic logic [4:0] sel_bit(input logic [2:0] s);
        logic [4:0] r;
        r = 5'h08;
        case (s)
            3'h0: r = 5'h08;
            3'h1: r = 5'h0A;
            3'h2: r = 5'h0C;
            3'h3: r = 5'h0E;
            3'h4: r = 5'h0F;
            3'h5: r = 5'h10;
            3'h6: r = 5'h11;
            default: r = 5'h12;
        endcase
        return r;
    endfunction : sel_bit

    assign key_field = wdt_ctrl_reg[wdrc_pkg::WDRC_KEY_LSB +: 5];
    assign sel_field = wdt_ctrl_reg[wdrc_pkg::WDRC_SEL_LSB +: 3];
    assign key_valid = key_ok(key_field);

    // ****************************************
    // wishbone slave
    // ****************************************
    // one wait state: ack one cycle after the request, dropped the next cycle
    assign bus_req = cyc_i && stb_i && !ack_reg && !err_o;
    assign hit = (adr_i == wdrc_pkg::WDRC_OFF_WDT_CTRL) ||
                 (adr_i == wdrc_pkg::WDRC_OFF_RST_FLAGS) ||
                 (adr_i == wdrc_pkg::WDRC_OFF_PROG_CTRL) ||
                 (adr_i == wdrc_pkg::WDRC_OFF_STATUS);
    assign wr_fire = bus_req && hit && we_i && sel_i[0];
    assign ctrl_wr = wr_fire && adr_i == wdrc_pkg::WDRC_OFF_WDT_CTRL;
    assign key_write_bad = ctrl_wr && !key_ok(dat_i[wdrc_pkg::WDRC_KEY_LSB +: 5]);
    assign prog_reset = wr_fire && adr_i == wdrc_pkg::WDRC_OFF_PROG_CTRL &&
                        dat_i[7:0] == wdrc_pkg::WDRC_PROG_RESET_CODE;
    assign ack_o = ack_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ack_reg <= bus_req && hit;
            err_o <= bus_req && !hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_req && !we_i) begin
            rdata_reg <= 32'h0000_0000;
            case (adr_i)
                wdrc_pkg::WDRC_OFF_WDT_CTRL: begin
                    rdata_reg[7:0] <= wdt_ctrl_reg;
                end
                wdrc_pkg::WDRC_OFF_RST_FLAGS: begin
                    rdata_reg[wdrc_pkg::WDRC_LVR_FLAG_BIT] <= lv_flag_reg;
                    rdata_reg[wdrc_pkg::WDRC_KEY_ERR_FLAG_BIT] <= key_flag_reg;
                end
                wdrc_pkg::WDRC_OFF_STATUS: begin
                    rdata_reg[wdrc_pkg::WDRC_ST_TIMEOUT_BIT] <= timeout_flag_o;
                    rdata_reg[wdrc_pkg::WDRC_ST_PDOWN_BIT] <= power_down_flag_o;
                    rdata_reg[wdrc_pkg::WDRC_ST_ENABLED_BIT] <= key_valid;
                end
                default: begin
                    rdata_reg <= 32'h0000_0000;
                end
            endcase
        end
    end
    assign dat_o = rdata_reg;

    // ****************************************
    // watchdog control register
    // ****************************************
    // power-on only; the device reset pulse leaves it as software set it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_ctrl_reg <= wdrc_pkg::WDRC_WDT_CTRL_RESET;
        end else if (ctrl_wr) begin
            wdt_ctrl_reg <= dat_i[7:0];
        end
    end

    // ****************************************
    // watchdog counter
    // ****************************************
    assign wdt_clear = key_write_bad || clear_wdt_i || halt_i;
    assign overflow = key_valid && low_speed_internal_osc_tick_i &&
                      wdt_cnt_reg[sel_bit(sel_field)];

    always_ff @(posedge clk_i) begin
        if (rst_i || wdt_clear || overflow || state_reg == wdrc_pkg::WDRC_RESETTING) begin
            wdt_cnt_reg <= '0;
        end else if (key_valid && low_speed_internal_osc_tick_i) begin
            wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
        end
    end

    // ****************************************
    // low voltage reset
    // ****************************************
    // no sleep/idle input other than the halt state, so power-down gates it
    wdrc_lv_filter #(
        .FILTER_TICKS(LV_FILTER)
    ) u_lv_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(low_speed_internal_osc_tick_i),
        .enable_i(!power_down_flag_o),
        .low_i(low_supply_i),
        .fire_o(lv_fire)
    );

    // ****************************************
    // reset sequencer
    // ****************************************
    assign full_reset_req = lv_fire || prog_reset ||
                            (overflow && !power_down_flag_o);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= wdrc_pkg::WDRC_RUN;
            key_cnt_reg <= 16'h0000;
            pulse_cnt_reg <= 2'h0;
        end else begin
            case (state_reg)
                wdrc_pkg::WDRC_RUN: begin
                    key_cnt_reg <= 16'h0000;
                    if (full_reset_req) begin
                        state_reg <= wdrc_pkg::WDRC_RESETTING;
                        pulse_cnt_reg <= 2'h0;
                    end else if (!key_valid) begin
                        state_reg <= wdrc_pkg::WDRC_KEY_WAIT;
                    end
                end
                wdrc_pkg::WDRC_KEY_WAIT: begin
                    if (full_reset_req) begin
                        state_reg <= wdrc_pkg::WDRC_RESETTING;
                        pulse_cnt_reg <= 2'h0;
                    end else if (key_valid) begin
                        state_reg <= wdrc_pkg::WDRC_RUN;
                    end else if (low_speed_internal_osc_tick_i) begin
                        if (key_cnt_reg >= 16'(KEY_ERR_DELAY - 1)) begin
                            state_reg <= wdrc_pkg::WDRC_RESETTING;
                            pulse_cnt_reg <= 2'h0;
                        end else begin
                            key_cnt_reg <= key_cnt_reg + 16'h0001;
                        end
                    end
                end
                wdrc_pkg::WDRC_RESETTING: begin
                    // hold the pulse long enough for the core to see it
                    if (pulse_cnt_reg == 2'(wdrc_pkg::WDRC_RESET_PULSE_CYC - 1)) begin
                        state_reg <= wdrc_pkg::WDRC_RUN;
                    end else begin
                        pulse_cnt_reg <= pulse_cnt_reg + 2'h1;
                    end
                end
                default: begin
                    state_reg <= wdrc_pkg::WDRC_RUN;
                end
            endcase
        end
    end

    // full reset covers pc to zero and ports high in the core
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            device_reset_o <= 1'b1;
        end else begin
            device_reset_o <= state_reg == wdrc_pkg::WDRC_RESETTING;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_sp_reset_o <= 1'b0;
        end else begin
            pc_sp_reset_o <= overflow && power_down_flag_o;
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timeout_flag_o <= 1'b0;
        end else if (overflow) begin
            timeout_flag_o <= 1'b1;
        end else if (halt_i || clear_wdt_i) begin
            timeout_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_down_flag_o <= 1'b0;
        end else if (halt_i || (overflow && power_down_flag_o)) begin
            power_down_flag_o <= 1'b1;
        end else if (clear_wdt_i) begin
            power_down_flag_o <= 1'b0;
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lv_flag_reg <= 1'b0;
        end else if (lv_fire) begin
            lv_flag_reg <= 1'b1;
        end else if (wr_fire && adr_i == wdrc_pkg::WDRC_OFF_RST_FLAGS &&
                     !dat_i[wdrc_pkg::WDRC_LVR_FLAG_BIT]) begin
            lv_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_flag_reg <= 1'b0;
        end else if (state_reg == wdrc_pkg::WDRC_KEY_WAIT && low_speed_internal_osc_tick_i &&
                     !key_valid && !full_reset_req &&
                     key_cnt_reg >= 16'(KEY_ERR_DELAY - 1)) begin
            key_flag_reg <= 1'b1;
        end else if (wr_fire && adr_i == wdrc_pkg::WDRC_OFF_RST_FLAGS &&
                     !dat_i[wdrc_pkg::WDRC_KEY_ERR_FLAG_BIT]) begin
            key_flag_reg <= 1'b0;
        end
    end

endmodule : wdrc_top

// ### tb/wdrc_core_model.sv
// Purpose: core and low-speed oscillator facing the watchdog
// Assumes: the bench asks for one clear or halt at a time
// Notes: instructions issue off the tick phase so tick counts stay exact
module wdrc_core_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // requests from the bench
    input wire logic clr_req_i,
    input wire logic halt_req_i,
    // to the block
    output logic tick_o,
    output logic clr_o,
    output logic halt_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] ph_reg;
    logic clr_pend_reg;
    logic halt_pend_reg;

    always_ff @(posedge clk_i) begin
        ph_reg <= rst_i ? 2'h0 : ph_reg + 2'h1;
        tick_o <= !rst_i && ph_reg == 2'h3;
    end

    // one single clear instruction per request, never a pair
    always_ff @(posedge clk_i) begin
        clr_pend_reg <= !rst_i && (clr_req_i || (clr_pend_reg && ph_reg != 2'h1));
        halt_pend_reg <= !rst_i && (halt_req_i || (halt_pend_reg && ph_reg != 2'h1));
        clr_o <= clr_pend_reg && ph_reg == 2'h1;
        halt_o <= halt_pend_reg && ph_reg == 2'h1;
    end
endmodule : wdrc_core_model

// ### tb/wdrc_top_chk.sv
// Purpose: port assertions for the watchdog and reset-control block
// Assumes: one clock, rst_i synchronous active high
// Notes: bound into every wdrc_top
module wdrc_top_chk #(
    parameter int KEY_ERR_DELAY = wdrc_pkg::WDRC_KEY_ERR_DELAY_LS,
    parameter int LV_FILTER = wdrc_pkg::WDRC_LV_FILTER_LS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic err_o,
    // core and system
    input wire logic low_speed_internal_osc_tick_i,
    input wire logic clear_wdt_i,
    input wire logic halt_i,
    input wire logic low_supply_i,
    // reset outputs
    input wire logic device_reset_o,
    input wire logic pc_sp_reset_o,
    input wire logic timeout_flag_o,
    input wire logic power_down_flag_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic req;
    logic mapped;
    assign req = cyc_i && stb_i && !ack_o && !err_o;
    assign mapped = adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****
    // properties
    // ****
    property p_ack; req && mapped |=> ack_o && !err_o; endproperty
    property p_err; req && !mapped |=> err_o && !ack_o; endproperty
    property p_rst_len; $rose(device_reset_o) |=> device_reset_o ##1 !device_reset_o; endproperty
    property p_to_cause; $rose(timeout_flag_o) |-> $past(low_speed_internal_osc_tick_i); endproperty
    property p_to_rst; $rose(timeout_flag_o) && !power_down_flag_o |-> ##[0:3] device_reset_o; endproperty
    property p_pd_keep; $rose(timeout_flag_o) && power_down_flag_o |-> !device_reset_o[*3]; endproperty
    property p_pc_flags; $rose(pc_sp_reset_o) |-> ##[0:1] (timeout_flag_o && power_down_flag_o); endproperty
    property p_pc_pulse; pc_sp_reset_o |=> !pc_sp_reset_o; endproperty
    property p_halt; halt_i && !clear_wdt_i |=> power_down_flag_o && !timeout_flag_o; endproperty
    property p_clr; clear_wdt_i && !halt_i |=> !power_down_flag_o && !timeout_flag_o; endproperty
    property p_prog;
        req && we_i && sel_i[0] && adr_i == 8'h08 && dat_i[7:0] == 8'h55 |-> ##[1:4] device_reset_o;
    endproperty
    property p_flags;
        ack_o && !$past(we_i) && $past(adr_i) == 8'h04 |-> dat_o[31:3] == 29'h0 && !dat_o[1];
    endproperty
    // ****
    // assertions
    // ****
    a_ack: assert property (p_ack) else $error("late ack");
    a_err: assert property (p_err) else $error("no error on unmapped address");
    a_rst_len: assert property (p_rst_len) else $error("device reset width");
    a_to_cause: assert property (p_to_cause) else $error("timeout without tick");
    a_to_rst: assert property (p_to_rst) else $error("timeout gave no reset");
    a_pd_keep: assert property (p_pd_keep) else $error("device reset in power-down");
    a_pc_flags: assert property (p_pc_flags) else $error("flags after pc reset");
    a_pc_pulse: assert property (p_pc_pulse) else $error("pc reset too long");
    a_halt: assert property (p_halt) else $error("halt flags");
    a_clr: assert property (p_clr) else $error("clear flags");
    a_prog: assert property (p_prog) else $error("reset code ignored");
    a_flags: assert property (p_flags) else $error("unused flag bits");
    c_dev: cover property ($rose(device_reset_o));
    c_pc: cover property ($rose(pc_sp_reset_o));
    c_err: cover property (err_o);
endmodule : wdrc_top_chk

bind wdrc_top wdrc_top_chk #(.KEY_ERR_DELAY(KEY_ERR_DELAY), .LV_FILTER(LV_FILTER)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .low_speed_internal_osc_tick_i(low_speed_internal_osc_tick_i), .clear_wdt_i(clear_wdt_i), .halt_i(halt_i),
    .low_supply_i(low_supply_i), .device_reset_o(device_reset_o),
    .pc_sp_reset_o(pc_sp_reset_o), .timeout_flag_o(timeout_flag_o),
    .power_down_flag_o(power_down_flag_o));

// ### tb/wdrc_top_tb.sv
// Purpose: self-checking bench for the watchdog and reset-control block
// Assumes: reads are scored from a queue when ack arrives
// Notes: ticks since the last clear or halt are counted by the monitor
module wdrc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int KD = 3;
    localparam int LF = 5;
    localparam logic [7:0] CTL = 8'h00;
    localparam logic [7:0] FLG = 8'h04;
    localparam logic [7:0] PRG = 8'h08;
    localparam logic [7:0] STA = 8'h0C;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, low_supply_i, clr_req, halt_req, dr_d;
    logic ack_o, err_o, tick, clr, halt, dev_rst, pc_rst, to_flag, pd_flag;
    logic [7:0] adr_i, v;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic [31:0] exp_q[$];
    int failures = 0;
    int comparisons = 0;
    int tick_cnt = 0;
    int rst_seen = 0;
    int n, s, t;

    wdrc_top #(.KEY_ERR_DELAY(KD), .LV_FILTER(LF)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .low_speed_internal_osc_tick_i(tick),
        .clear_wdt_i(clr), .halt_i(halt), .low_supply_i(low_supply_i),
        .device_reset_o(dev_rst), .pc_sp_reset_o(pc_rst), .timeout_flag_o(to_flag),
        .power_down_flag_o(pd_flag));
    wdrc_core_model core (.clk_i(clk_i), .rst_i(rst_i), .clr_req_i(clr_req),
        .halt_req_i(halt_req), .tick_o(tick), .clr_o(clr), .halt_o(halt));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic chk1(input string nm, input logic seen, input logic exp);
        check(nm, {31'h0, seen}, {31'h0, exp});
    endtask : chk1

    task automatic report_and_stop;
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // ****
    // monitor: scores reads, counts resets and ticks
    // ****
    always @(posedge clk_i) begin
        tick_cnt <= (clr || halt) ? 0 : tick_cnt + int'(tick);
        if (ack_o && !we_i && exp_q.size() > 0) check("read data", dat_o, exp_q.pop_front());
        if (dev_rst && !dr_d && !rst_i) rst_seen++;
        dr_d <= dev_rst;
    end

    // for a read, d is the expected data
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee);
        if (!w && !ee) exp_q.push_back(d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        // no local limit: only the watchdog process ends a hung wait
        do @(posedge clk_i); while (!ack_o && !err_o);
        check("bus answer", {30'h0, ack_o, err_o}, {30'h0, !ee, ee});
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic instr(input logic h);
        halt_req <= h;
        clr_req <= !h;
        @(posedge clk_i);
        halt_req <= 1'b0;
        clr_req <= 1'b0;
        repeat (7) @(posedge clk_i);
    endtask : instr

    // cnt is the tick count at the event, -1 if it never came
    task automatic wait_ev(input logic pc, output int cnt);
        cnt = -1;
        for (int c = 0; c < 9000; c++) begin
            @(posedge clk_i);
            if (pc ? pc_rst : dev_rst) begin
                cnt = tick_cnt;
                break;
            end
        end
    endtask : wait_ev

    task automatic chk_rst(input int base, input int cyc, input logic want);
        repeat (cyc) @(posedge clk_i);
        chk1("device reset", rst_seen != base, want);
    endtask : chk_rst

    initial begin
        repeat (40000) @(posedge clk_i);
        failures++;
        report_and_stop();
    end

    initial begin
        void'($urandom(12));
        {rst_i, cyc_i, stb_i, we_i, low_supply_i, clr_req, halt_req} = 7'h40;
        {adr_i, sel_i, dat_i} = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(0, CTL, 32'h53, 0);
        bus(0, FLG, 32'h0, 0);
        bus(0, STA, 32'h4, 0);
        bus(0, 8'h10, 32'h0, 1);
        bus(1, 8'h14, 32'h55, 1);
        for (int i = 0; i < 8; i++) begin
            v = {($urandom_range(1) != 0) ? 5'h0A : 5'h15, i[2:0]};
            bus(1, CTL, {24'h0, v}, 0);
            bus(0, CTL, {24'h0, v}, 0);
        end
        bus(1, CTL, 32'h53, 0);
        instr(0);
        t = tick_cnt;
        bus(1, CTL, 32'hFB, 0);
        wait_ev(0, n);
        bus(1, CTL, 32'h53, 0);
        chk1("key delay", n - t >= KD && n - t <= KD + 2, 1'b1);
        bus(0, FLG, 32'h1, 0);
        bus(1, FLG, 32'h0, 0);
        bus(0, FLG, 32'h0, 0);
        s = rst_seen;
        bus(1, PRG, 32'h54, 0);
        chk_rst(s, 10, 0);
        bus(1, PRG, 32'h55, 0);
        chk_rst(s, 6, 1);
        s = rst_seen;
        low_supply_i <= 1'b1;
        repeat (LF * 4) @(posedge clk_i);
        low_supply_i <= 1'b0;
        chk_rst(s, 20, 0);
        low_supply_i <= 1'b1;
        wait_ev(0, n);
        low_supply_i <= 1'b0;
        bus(0, FLG, 32'h4, 0);
        bus(1, FLG, 32'hFA, 0);
        bus(0, FLG, 32'h0, 0);
        instr(1);
        s = rst_seen;
        low_supply_i <= 1'b1;
        repeat (LF * 4 + 20) @(posedge clk_i);
        low_supply_i <= 1'b0;
        chk_rst(s, 4, 0);
        instr(0);
        bus(1, CTL, 32'hA8, 0);
        instr(0);
        repeat (3) begin
            repeat (800) @(posedge clk_i);
            instr(0);
        end
        chk_rst(s, 1, 0);
        for (int k = 0; k < 2; k++) begin
            bus(1, CTL, {24'h0, 5'h0A, 3'(k)}, 0);
            instr(0);
            wait_ev(0, n);
            check("ticks to timeout", n, (32'h1 << (8 + 2 * k)) + 32'h1);
            repeat (3) @(posedge clk_i);
            chk1("timeout flag", to_flag, 1'b1);
        end
        bus(1, CTL, 32'h50, 0);
        instr(1);
        chk1("power-down flag", pd_flag, 1'b1);
        s = rst_seen;
        wait_ev(1, n);
        check("ticks in power-down", n, 32'd257);
        repeat (2) @(posedge clk_i);
        check("flags", {30'h0, to_flag, pd_flag}, 32'h3);
        chk_rst(s, 1, 0);
        instr(0);
        chk1("power-down flag", pd_flag, 1'b0);
        report_and_stop();
    end
endmodule : wdrc_top_tb
